// *** core/rcf_pkg.sv ***
/*
 * rcf_pkg: shared constants of the channel frequency select block.
 * Assumes a single 10 MHz clock domain; frequencies are in 100 kHz units.
 */
package rcf_pkg;
	// register offsets
	localparam logic [7:0] OFS_CHANNEL_CCA = 8'h08;
	localparam logic [7:0] OFS_FINE_CHANNEL = 8'h14;
	localparam logic [7:0] OFS_BAND_SELECT = 8'h15;
	localparam logic [7:0] OFS_STATUS = 8'h16;
	// field positions
	localparam int CHANNEL_MSB = 4;
	localparam int CHANNEL_LSB = 0;
	localparam int BAND_MSB = 2;
	localparam int BAND_LSB = 0;
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_TX_BIT = 1;
	// reset values
	localparam logic [7:0] RST_CHANNEL_CCA = 8'h00;
	localparam logic [7:0] RST_FINE_CHANNEL = 8'h00;
	localparam logic [7:0] RST_BAND_SELECT = 8'h00;
	// frequency width in 100 kHz units (max 935.0 MHz = 9350)
	localparam int FREQ_W = 14;
	localparam logic [13:0] RST_FREQ = 14'h0000;
	// band bases and steps, 100 kHz units
	localparam logic [13:0] EU_CHANNEL_FREQ = 14'd8683;
	localparam logic [13:0] NA_BASE_FREQ = 14'd9060;
	localparam logic [13:0] NA_STEP = 14'd20;
	localparam logic [4:0] NA_LAST_CHANNEL = 5'h0a;
	localparam logic [13:0] BAND1_BASE = 14'd7690;
	localparam logic [13:0] BAND2_BASE = 14'd8570;
	localparam logic [13:0] BAND3_BASE = 14'd9030;
	localparam logic [13:0] BAND4_BASE = 14'd7690;
	localparam logic [13:0] BAND5_BASE = 14'd8330;
	localparam logic [13:0] BAND6_BASE = 14'd9020;
	localparam logic [13:0] FINE_STEP = 14'd1;
	localparam logic [13:0] COARSE_STEP = 14'd10;
	localparam logic [7:0] BAND4_MAX = 8'h5e;
	localparam logic [7:0] BAND5_MAX = 8'h66;
	// receive/idle offset below the carrier: 1 MHz
	localparam logic [13:0] RX_OFFSET = 14'd10;
endpackage : rcf_pkg

// *** core/rcf_dec_if.sv ***
/*
 * rcf_dec_if: carries the channel fields into the decoder and the
 * decoded carrier back. Assumes both ends share one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface rcf_dec_if;
	logic [2:0] band_selector;
	logic [7:0] fine_channel_number;
	logic [4:0] channel;
	logic [13:0] carrier;
	logic valid;

	modport dec (
		input band_selector,
		input fine_channel_number,
		input channel,
		output carrier,
		output valid
	);
	modport user (
		output band_selector,
		output fine_channel_number,
		output channel,
		input carrier,
		input valid
	);
endinterface : rcf_dec_if
`default_nettype wire

// *** core/rcf_decoder.sv ***
/*
 * rcf_decoder: purely combinational band/channel to carrier decode.
 * Assumes the fields are stable registers of the top module.
 */
`timescale 1ns/1ps
`default_nettype none
module rcf_decoder (
	rcf_dec_if.dec dif // channel fields in, carrier out
);
	// base plus step times number, cut to frequency width
	function automatic logic [13:0] lin_freq(input logic [13:0] base,
		input logic [13:0] step, input logic [7:0] num);
		logic [21:0] prod;
		prod = 22'(step) * 22'(num);
		return base + prod[13:0];
	endfunction

	wire logic [4:0] ch = dif.channel;
	wire logic [7:0] num = dif.fine_channel_number;
	wire logic [7:0] na_idx = {3'h0, ch - 5'h01};
	// band 0 ignores the fine number entirely
	wire logic ch_valid = (ch <= rcf_pkg::NA_LAST_CHANNEL); // [RQ11]
	wire logic [13:0] band0_freq = (ch == 5'h00) ?
		rcf_pkg::EU_CHANNEL_FREQ : // [RQ9]
		lin_freq(rcf_pkg::NA_BASE_FREQ, rcf_pkg::NA_STEP, na_idx); // [RQ10]

	// per-band formulas; band 7 reserved
	always_comb begin
		dif.carrier = rcf_pkg::RST_FREQ;
		dif.valid = 1'b1;
		case (dif.band_selector)
			3'h0: begin
				dif.carrier = band0_freq; // [RQ1]
				dif.valid = ch_valid; // [RQ11]
			end
			3'h1: dif.carrier = lin_freq(rcf_pkg::BAND1_BASE,
				rcf_pkg::FINE_STEP, num); // [RQ2]
			3'h2: dif.carrier = lin_freq(rcf_pkg::BAND2_BASE,
				rcf_pkg::FINE_STEP, num); // [RQ3]
			3'h3: dif.carrier = lin_freq(rcf_pkg::BAND3_BASE,
				rcf_pkg::FINE_STEP, num); // [RQ4]
			3'h4: begin
				dif.carrier = lin_freq(rcf_pkg::BAND4_BASE,
					rcf_pkg::COARSE_STEP, num); // [RQ5]
				dif.valid = (num <= rcf_pkg::BAND4_MAX); // [RQ5]
			end
			3'h5: begin
				dif.carrier = lin_freq(rcf_pkg::BAND5_BASE,
					rcf_pkg::COARSE_STEP, num); // [RQ6]
				dif.valid = (num <= rcf_pkg::BAND5_MAX); // [RQ6]
			end
			3'h6: dif.carrier = lin_freq(rcf_pkg::BAND6_BASE,
				rcf_pkg::FINE_STEP, num); // [RQ7]
			default: dif.valid = 1'b0; // [RQ14]
		endcase
	end
endmodule : rcf_decoder
`default_nettype wire

// *** core/rcf_top.sv ***
/*
 * rcf_top: channel configuration registers, carrier decode and the
 * synthesizer frequency with its calibration start pulse.
 * Assumes a synchronous register port and a level telling transmit.
 */
// Notes on behaviour
// [RQ1] band 0 takes carrier from the standard channel field, ignoring fine number
// [RQ2] band 1: 769.0 MHz plus 0.1 MHz per fine number, 0x00-0xFF
// [RQ3] band 2: 857.0 MHz plus 0.1 MHz per fine number, full range
// [RQ4] band 3: 903.0 MHz plus 0.1 MHz per fine number, full range
// [RQ5] band 4: 769 MHz plus 1 MHz per number, valid 0x00-0x5E
// [RQ6] band 5: 833 MHz plus 1 MHz per number, valid 0x00-0x66
// [RQ7] band 6: 902.0 MHz plus 0.1 MHz per fine number, full range
// [RQ8] standard channel field is bits 4:0 of register at 0x08
// [RQ9] band 0, channel 0 selects 868.3 MHz
// [RQ10] band 0, channel k 1..10 selects 906 MHz plus 2 MHz times (k-1)
// [RQ11] standard channel values above 0x0A are reserved and invalid
// [RQ12] any carrier change starts both calibration loops
// [RQ13] synthesizer 1 MHz below carrier except in transmit states
// [RQ14] band selector 7 is reserved and flagged invalid
// [RQ15] carrier is given as a count of 100 kHz units
`timescale 1ns/1ps
`default_nettype none
module rcf_top (
	input wire logic clock, // 10 MHz clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] reg_addr, // register offset
	input wire logic reg_wr, // write strobe
	input wire logic [7:0] reg_wdata, // write data
	input wire logic tx_state, // high in transmit states
	output logic [7:0] reg_rdata_ff, // read data, one cycle late
	output logic [13:0] carrier_ff, // decoded carrier, 100 kHz units
	output logic [13:0] synth_freq_ff, // synthesizer setting
	output logic freq_valid_ff, // selection defines a channel
	output logic cal_start_ff // pulse: start both calibrations
);
	logic [7:0] channel_cca_control_ff;
	logic [7:0] fine_channel_register_ff;
	logic [7:0] band_select_register_ff;
	logic [7:0] nxt_rdata;
	logic [13:0] nxt_carrier;
	logic [13:0] nxt_synth;
	logic nxt_cal;

	rcf_dec_if dif ();

	// write decode
	wire logic wr_cca = reg_wr && (reg_addr == rcf_pkg::OFS_CHANNEL_CCA);
	wire logic wr_fine = reg_wr && (reg_addr == rcf_pkg::OFS_FINE_CHANNEL);
	wire logic wr_band = reg_wr && (reg_addr == rcf_pkg::OFS_BAND_SELECT);

	// field extraction into the decoder
	assign dif.channel = channel_cca_control_ff[rcf_pkg::CHANNEL_MSB:
		rcf_pkg::CHANNEL_LSB]; // [RQ8]
	assign dif.fine_channel_number = fine_channel_register_ff;
	assign dif.band_selector = band_select_register_ff[rcf_pkg::BAND_MSB:
		rcf_pkg::BAND_LSB];

	rcf_decoder u_dec (
		.dif(dif.dec)
	);

	// configuration registers; upper cca bits kept as plain storage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			channel_cca_control_ff <= rcf_pkg::RST_CHANNEL_CCA;
			fine_channel_register_ff <= rcf_pkg::RST_FINE_CHANNEL;
			band_select_register_ff <= rcf_pkg::RST_BAND_SELECT;
		end else begin
			if (wr_cca) channel_cca_control_ff <= reg_wdata; // [RQ8]
			if (wr_fine) fine_channel_register_ff <= reg_wdata;
			if (wr_band) band_select_register_ff <= reg_wdata;
		end
	end

	// read mux; unmapped offsets read zero, band bits above 2:0 read zero
	always_comb begin
		nxt_rdata = 8'h00;
		case (reg_addr)
			rcf_pkg::OFS_CHANNEL_CCA: nxt_rdata = channel_cca_control_ff;
			rcf_pkg::OFS_FINE_CHANNEL: nxt_rdata = fine_channel_register_ff;
			rcf_pkg::OFS_BAND_SELECT:
				nxt_rdata = {5'h00, band_select_register_ff[2:0]};
			rcf_pkg::OFS_STATUS: begin
				nxt_rdata[rcf_pkg::STAT_VALID_BIT] = freq_valid_ff;
				nxt_rdata[rcf_pkg::STAT_TX_BIT] = tx_state;
			end
			default: nxt_rdata = 8'h00;
		endcase
	end

	// an invalid selection keeps the last good carrier rather than
	// steering the synthesizer to a reserved frequency
	assign nxt_carrier = dif.valid ? dif.carrier : carrier_ff; // [RQ14]
	// calibration only on a real carrier change, not the tx step
	assign nxt_cal = dif.valid && (dif.carrier != carrier_ff); // [RQ12]
	assign nxt_synth = tx_state ? nxt_carrier :
		nxt_carrier - rcf_pkg::RX_OFFSET; // [RQ13]

	// output registers; carrier and synthesizer in 100 kHz units
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff <= 8'h00;
			carrier_ff <= rcf_pkg::RST_FREQ;
			synth_freq_ff <= rcf_pkg::RST_FREQ;
			freq_valid_ff <= 1'b0;
			cal_start_ff <= 1'b0;
		end else begin
			reg_rdata_ff <= nxt_rdata;
			carrier_ff <= nxt_carrier; // [RQ15]
			synth_freq_ff <= nxt_synth; // [RQ13]
			freq_valid_ff <= dif.valid; // [RQ11]
			cal_start_ff <= nxt_cal; // [RQ12]
		end
	end
endmodule : rcf_top
`default_nettype wire

// *** verification/rcf_top_properties.sv ***
/* rcf_top_properties: port-level checks of rcf_top.
 * Assumes the bind below and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module rcf_top_properties (
	input wire logic clock, // clock
	input wire logic rst_n, // reset
	input wire logic [7:0] reg_addr, // offset
	input wire logic reg_wr, // write
	input wire logic [7:0] reg_wdata, // data
	input wire logic tx_state, // transmit
	input wire logic [7:0] reg_rdata_ff, // read data
	input wire logic [13:0] carrier_ff, // carrier
	input wire logic [13:0] synth_freq_ff, // synth
	input wire logic freq_valid_ff, // valid
	input wire logic cal_start_ff // cal pulse
);
	// all checks share the one clock and reset
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	synth_tx_a:
	assert property (tx_state ##1 $stable(carrier_ff) |->
		synth_freq_ff == carrier_ff) else $error("synth off in tx");
	synth_rx_a:
	assert property (!tx_state ##1 $stable(carrier_ff) |->
		synth_freq_ff == carrier_ff - rcf_pkg::RX_OFFSET)
		else $error("synth off in rx");
	cal_on_change_a:
	assert property (carrier_ff != $past(carrier_ff) |-> cal_start_ff)
		else $error("no cal on change");
	cal_only_a:
	assert property (cal_start_ff |-> carrier_ff != $past(carrier_ff))
		else $error("cal without change");
	hold_invalid_a:
	assert property (!freq_valid_ff |-> $stable(carrier_ff))
		else $error("carrier moved while invalid");
	cal_valid_a:
	assert property (cal_start_ff |-> freq_valid_ff)
		else $error("cal on invalid");
	carrier_range_a:
	assert property (freq_valid_ff |-> carrier_ff >= 14'h1e0a &&
		carrier_ff <= 14'h2486) else $error("carrier out of range");
	channel_back_a:
	assert property (reg_wr && reg_addr == 8'h08 ##1 !reg_wr &&
		reg_addr == 8'h08 |=> reg_rdata_ff == $past(reg_wdata, 2))
		else $error("channel readback");
endmodule // rcf_top_properties
bind rcf_top rcf_top_properties i_rcf_top_properties (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .tx_state(tx_state), .reg_rdata_ff(reg_rdata_ff),
	.carrier_ff(carrier_ff), .synth_freq_ff(synth_freq_ff),
	.freq_valid_ff(freq_valid_ff), .cal_start_ff(cal_start_ff));
`default_nettype wire

// *** verification/rcf_top_test.sv ***
/* rcf_top_test: directed bench for channel decode and registers.
 * Assumes rcf_top timing: decode lands two edges after a write. */
`timescale 1ns/1ps
`default_nettype none
module rcf_top_test;
	logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, tx_state = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
	logic [13:0] carrier_ff, synth_freq_ff;
	logic freq_valid_ff, cal_start_ff;
	int num_errors = 0, check_count = 0;
	int base[7] = '{0, 7690, 8570, 9030, 7690, 8330, 9020};
	int step[7] = '{0, 1, 1, 1, 10, 10, 1};
	int top[7] = '{0, 255, 255, 255, 94, 102, 255};
	rcf_top i_rcf_top (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .tx_state(tx_state),
		.reg_rdata_ff(reg_rdata_ff), .carrier_ff(carrier_ff),
		.synth_freq_ff(synth_freq_ff), .freq_valid_ff(freq_valid_ff),
		.cal_start_ff(cal_start_ff));
	// 100 ns clock
	initial begin
		forever #50 clock = ~clock;
	end
	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// write, then let the decode edge pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		@(negedge clock);
		chk({6'h00, reg_rdata_ff}, {6'h00, exp});
	endtask
	task automatic band_zero;
		int k;
		chk(carrier_ff, 14'd8683);
		rd(8'h15, 8'h00);
		wr(8'h14, 8'h55);
		for (k = 1; k <= 10; k++) begin
			wr(8'h08, k[7:0]);
			chk(carrier_ff, 14'(9060 + 20 * (k - 1)));
			chk({13'h0000, cal_start_ff}, 14'h0001);
		end
		wr(8'h08, 8'h0b);
		chk({13'h0000, freq_valid_ff}, 14'h0000);
		chk(carrier_ff, 14'd9240);
		wr(8'h08, 8'he0);
		chk(carrier_ff, 14'd8683);
		rd(8'h08, 8'he0);
	endtask
	// bands 1..6 at both ends of their range, then reserved band 7
	task automatic bands;
		int b;
		for (b = 1; b <= 6; b++) begin
			wr(8'h14, 8'h00);
			wr(8'h15, b[7:0]);
			chk(carrier_ff, 14'(base[b]));
			wr(8'h14, top[b][7:0]);
			chk(carrier_ff, 14'(base[b] + step[b] * top[b]));
			if (step[b] == 10) begin
				wr(8'h14, 8'(top[b] + 1));
				chk({13'h0000, freq_valid_ff}, 14'h0000);
			end
		end
		wr(8'h15, 8'h07);
		chk({13'h0000, freq_valid_ff}, 14'h0000);
		rd(8'h16, 8'h00);
		wr(8'h15, 8'h06);
		tx_state = 1'b1;
		repeat (2) @(negedge clock);
		chk(synth_freq_ff, 14'd9275);
		chk({13'h0000, cal_start_ff}, 14'h0000);
		rd(8'h16, 8'h03);
		tx_state = 1'b0;
		repeat (2) @(negedge clock);
		chk(synth_freq_ff, 14'd9265);
		rd(8'h16, 8'h01);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		#1ms;
		num_errors++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		repeat (2) @(negedge clock);
		band_zero();
		bands();
		report_and_stop();
	end
endmodule // rcf_top_test
`default_nettype wire
